// file: scan_linker_regs.sv
// data registers and serial data flow of the scan-path linker
`timescale 1ns/1ps
`include "scan_linker_defs.svh"
module scan_linker_regs
	import scan_linker_pkg::*;
#(
	parameter int NCH = `NUM_CHAINS,
	parameter int LOG_DEPTH = `LOG_DEPTH
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdi_i,
	output logic tdo_o,
	output logic tdo_oe_o,
	input wire tap_state_e tap_state_i,
	input wire data_reg_e instr_reg_i,
	output logic ir_scan_in_o,
	input wire logic ir_scan_out_i,
	input wire logic [`CTL_WIDTH-1:0] control_word_i,
	output logic [NCH-1:0] chain_mode_select_out_o,
	output logic [NCH-1:0] chain_data_out_o,
	output logic [NCH-1:0] chain_data_out_oe_o,
	input wire logic [NCH-1:0] chain_data_in_i,
	input wire logic condition_input_i,
	input wire logic master_condition_in_i,
	input wire logic func_master_cond_out_i,
	input wire logic func_cond_out_i,
	input wire logic func_cond_out_oe_i,
	input wire logic func_cond_out_ts_en_n_i,
	input wire logic func_cond_out_od_en_n_i,
	input wire logic boundary_drive_i,
	output logic master_condition_out_o,
	output logic condition_output_o,
	output logic condition_output_oe_o,
	input wire logic [`TAG_BUS_WIDTH-1:0] tag_bus_pins_i,
	output logic [`TAG_BUS_WIDTH-1:0] tag_bus_pins_o,
	output logic [`TAG_BUS_WIDTH-1:0] tag_bus_pins_oe_o,
	output logic count_end_n_o,
	output logic count_end_to_cond_out_o,
	output logic count_log_valid_o,
	input wire logic count_log_ready_i,
	output logic [`COUNT_WIDTH-1:0] count_log_data_o
);
	localparam int TW = `TAG_BUS_WIDTH;
	localparam int BW = `BOUNDARY_WIDTH;
	localparam int CW = `COUNT_WIDTH;
	localparam int SW = `CHAIN_SEL_WIDTH;
	localparam int NPIN = 4 + 1 + NCH + TW;

	// pin synchronisers: first stage is read only by the second
	logic [NPIN-1:0] pin_meta;	// first stage
	logic [NPIN-1:0] pin_sync;	// second stage, safe to use
	wire [NPIN-1:0] pin_raw = {tag_bus_pins_i, chain_data_in_i, master_condition_in_i,
		condition_input_i, tdi_i, tms_i, tck_i};

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
		end
	end

	// named views of the synchronised pins
	wire tck_s = pin_sync[0];
	wire tms_s = pin_sync[1];
	wire tdi_s = pin_sync[2];
	wire cond_in_s = pin_sync[3];
	wire master_cond_in_s = pin_sync[4];
	wire [NCH-1:0] chain_in_s = pin_sync[5 +: NCH];
	wire [TW-1:0] tag_s = pin_sync[5 + NCH +: TW];

	// previous samples for edge detection
	logic tck_prev;	// last test clock level
	logic cond_prev;	// last condition input level

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tck_prev <= 1'b0;
			cond_prev <= 1'b0;
		end else begin
			tck_prev <= tck_s;
			cond_prev <= cond_in_s;
		end
	end

	// test clock edges and state decode
	wire tck_rise = tck_s & ~tck_prev;
	wire tck_fall = ~tck_s & tck_prev;
	wire st_reset = (tap_state_i == tap_reset);
	wire st_idle = (tap_state_i == tap_idle);
	wire st_capture = (tap_state_i == tap_capture_dr);
	wire st_shift_dr = (tap_state_i == tap_shift_dr);
	wire st_shift_ir = (tap_state_i == tap_shift_ir);
	wire st_update = (tap_state_i == tap_update_dr);
	wire st_update_ir = (tap_state_i == tap_update_ir);
	wire st_shifting = st_shift_dr | st_shift_ir;

	// register chosen by the instruction, latched at Update-IR fall
	data_reg_e dr_sel;	// selected internal register
	data_reg_e next_dr_sel;	// decoded instruction, unknown codes fall back to bypass

	always_comb begin
		next_dr_sel = reg_bypass;
		unique case (instr_reg_i)
			reg_bypass: next_dr_sel = reg_bypass;
			reg_select: next_dr_sel = reg_select;
			reg_boundary: next_dr_sel = reg_boundary;
			reg_tag_bus: next_dr_sel = reg_tag_bus;
			reg_counter: next_dr_sel = reg_counter;
			default: next_dr_sel = reg_bypass;
		endcase
	end

	// power-up and test reset both place the bypass cell in the path
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			dr_sel <= reg_bypass;
		end else if (st_reset) begin
			dr_sel <= reg_bypass;
		end else if (tck_fall && st_update_ir) begin
			dr_sel <= next_dr_sel;
		end
	end

	// per-register strobes
	wire is_sel = (dr_sel == reg_select);
	wire is_bnd = (dr_sel == reg_boundary);
	wire is_tag = (dr_sel == reg_tag_bus);
	wire is_byp = (dr_sel == reg_bypass);
	wire is_cnt = (dr_sel == reg_counter);
	wire do_capture = tck_rise & st_capture;
	wire do_shift = tck_rise & st_shift_dr;
	wire do_update = tck_fall & st_update;

	// chain select register: shift stage and applied stage
	logic [SW-1:0] sel_shift;	// serial stage
	logic [SW-1:0] chain_select;	// applied value steering the chains
	logic follow_hold;	// first follower waits for idle

	wire [NCH-1:0] new_follow;	// chains the shifted value would make follow
	wire [NCH-1:0] follow_mask;	// chains now following TMS
	wire [NCH:0] path;	// serial path through active chains

	// first chain is fed from TDI, each active chain returns into the next stage
	assign path[0] = tdi_s;

	genvar k;
	generate
		for (k = 0; k < NCH; k++) begin : g_chain
			logic dly;	// one-flop delay ahead of the chain
			logic ms;	// registered mode-select level

			// upper bit of each field selects follow mode
			assign new_follow[k] = sel_shift[2 * k + 1];
			assign follow_mask[k] = chain_select[2 * k + 1];
			assign path[k + 1] = follow_mask[k] ? chain_in_s[k] : path[k];

			// delay stage sampled on the test clock in shift states
			always_ff @(posedge mclk_i or negedge arst_n_i) begin
				if (!arst_n_i)
					dly <= 1'b0;
				else if (tck_rise && st_shifting)
					dly <= path[k];
			end

			// mode-select: static from the lower bit, or TMS while following
			always_ff @(posedge mclk_i or negedge arst_n_i) begin
				if (!arst_n_i)
					ms <= 1'b1;
				else if (!follow_mask[k])
					ms <= ~chain_select[2 * k];
				else
					ms <= follow_hold ? 1'b0 : tms_s;
			end

			assign chain_mode_select_out_o[k] = ms;
			assign chain_data_out_o[k] = dly;
			// data out drives only for following chains in shift states
			assign chain_data_out_oe_o[k] = follow_mask[k] & st_shifting;
		end
	endgenerate

	// serial input of the internal register, after every active chain
	wire int_in = path[NCH];
	assign ir_scan_in_o = int_in;

	// select register shift, capture and update
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			sel_shift <= `CHAIN_SEL_RESET;
			chain_select <= `CHAIN_SEL_RESET;
		end else if (st_reset) begin
			sel_shift <= `CHAIN_SEL_RESET;
			chain_select <= `CHAIN_SEL_RESET;
		end else if (is_sel) begin
			if (do_capture)
				sel_shift <= chain_select;
			else if (do_shift)
				sel_shift <= {int_in, sel_shift[SW-1:1]};
			else if (do_update)
				chain_select <= sel_shift;
		end
	end

	// hold-low flag for a chain selected while none was following
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			follow_hold <= 1'b0;
		end else if (st_reset) begin
			follow_hold <= 1'b0;
		end else if (is_sel && do_update) begin
			// hand-over is immediate when another chain already follows
			follow_hold <= (|new_follow) & ~(|follow_mask);
		end else if (tck_fall && st_idle) begin
			follow_hold <= 1'b0;
		end
	end

	// bypass cell: captures zero, shifts one bit
	logic bypass_cell;	// single bypass stage

	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			bypass_cell <= `BYPASS_CAPTURE;
		else if (is_byp && do_capture)
			bypass_cell <= `BYPASS_CAPTURE;
		else if (is_byp && do_shift)
			bypass_cell <= int_in;
	end

	// boundary cells: shift stage and update latch, neither reset
	logic [BW-1:0] boundary_cells;	// serial stage
	logic [BW-1:0] boundary_upd;	// update latch forcing the pins
	wire [BW-1:0] boundary_capt = {master_cond_in_s, func_master_cond_out_i, cond_in_s,
		func_cond_out_ts_en_n_i, func_cond_out_od_en_n_i, func_cond_out_i, tag_s};

	always_ff @(posedge mclk_i) begin
		if (is_bnd && do_capture)
			boundary_cells <= boundary_capt;
		else if (is_bnd && do_shift)
			boundary_cells <= {int_in, boundary_cells[BW-1:1]};
		else if (is_tag && do_capture)
			boundary_cells[TW-1:0] <= tag_s;
		else if (is_tag && do_shift)
			boundary_cells[TW-1:0] <= {int_in, boundary_cells[TW-1:1]};
	end

	always_ff @(posedge mclk_i) begin
		if (is_bnd && do_update)
			boundary_upd <= boundary_cells;
		else if (is_tag && do_update)
			boundary_upd[TW-1:0] <= boundary_cells[TW-1:0];
	end

	// forced open-drain drive pulls low only when its enable and data are low
	wire forced_oe = ~boundary_upd[`BND_COND_OUT_TS_EN_N]
		| (~boundary_upd[`BND_COND_OUT_OD_EN_N] & ~boundary_upd[`BND_COND_OUT]);

	// pin drivers: functional values, tag bus released, unless the boundary forces them
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			master_condition_out_o <= 1'b0;
			condition_output_o <= 1'b0;
			condition_output_oe_o <= 1'b0;
			tag_bus_pins_o <= '0;
			tag_bus_pins_oe_o <= '0;
		end else if (boundary_drive_i) begin
			master_condition_out_o <= boundary_upd[`BND_MASTER_COND_OUT];
			condition_output_o <= boundary_upd[`BND_COND_OUT];
			condition_output_oe_o <= forced_oe;
			tag_bus_pins_o <= boundary_upd[TW-1:0];
			tag_bus_pins_oe_o <= '1;
		end else begin
			master_condition_out_o <= func_master_cond_out_i;
			condition_output_o <= func_cond_out_i;
			condition_output_oe_o <= func_cond_out_oe_i;
			tag_bus_pins_o <= '0;
			tag_bus_pins_oe_o <= '0;
		end
	end

	// counter: shift register, counter value and event bookkeeping
	logic [CW-1:0] event_counter_shift;	// serial stage, reset clears it
	logic [CW-1:0] count_value;	// the counter itself, never reset
	logic event_pending;	// a counted edge waiting for log room

	wire dir_down = control_word_i[`CTL_DIR_DOWN];
	wire stop_zero = control_word_i[`CTL_STOP_ZERO];
	wire edge_fall = control_word_i[`CTL_EDGE_FALL];
	wire [1:0] route = {control_word_i[`CTL_ROUTE_HI], control_word_i[`CTL_ROUTE_LO]};
	wire cond_rise = cond_in_s & ~cond_prev;
	wire cond_fall = ~cond_in_s & cond_prev;
	wire cond_edge = edge_fall ? cond_fall : cond_rise;
	wire preload = is_cnt & do_update;
	// stop-at-zero only holds the count in down mode
	wire stopped = dir_down & stop_zero & (count_value == `COUNT_ALL_ZERO);
	wire log_ready;	// room in the log buffer
	wire count_fire = event_pending & log_ready & ~stopped & ~preload;
	wire [CW-1:0] next_count = dir_down ? count_value - 1'b1 : count_value + 1'b1;
	wire count_end_reached = dir_down ? (count_value == `COUNT_ALL_ZERO)
		: (count_value == `COUNT_ALL_ONE);

	// shift register: cleared by reset, captures the counter for scan-out
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			event_counter_shift <= `COUNT_SHIFT_RESET;
		else if (st_reset)
			event_counter_shift <= `COUNT_SHIFT_RESET;
		else if (is_cnt && do_capture)
			event_counter_shift <= count_value;
		else if (is_cnt && do_shift)
			event_counter_shift <= {int_in, event_counter_shift[CW-1:1]};
	end

	// counter value: preload wins over counting in the same cycle
	always_ff @(posedge mclk_i) begin
		if (preload)
			count_value <= event_counter_shift;
		else if (count_fire)
			count_value <= next_count;
	end

	// edges while stopped are ignored; a new edge wins over the clear
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i)
			event_pending <= 1'b0;
		else if (cond_edge)
			event_pending <= 1'b1;
		else if (count_fire || stopped)
			event_pending <= 1'b0;
	end

	// count-end flag and its routing toward the condition output
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			count_end_n_o <= 1'b1;
			count_end_to_cond_out_o <= 1'b0;
		end else begin
			count_end_n_o <= ~count_end_reached;
			count_end_to_cond_out_o <= (route == `CTL_ROUTE_COUNT_END);
		end
	end

	// every counted value is logged, preloads are not; a full log stalls counting
	sync_fifo #(
		.WIDTH(CW),
		.DEPTH(LOG_DEPTH)
	) u_count_log (
		.mclk_i(mclk_i),
		.arst_n_i(arst_n_i),
		.in_valid_i(count_fire),
		.in_ready_o(log_ready),
		.in_data_i(next_count),
		.out_valid_o(count_log_valid_o),
		.out_ready_i(count_log_ready_i),
		.out_data_o(count_log_data_o)
	);

	// last stage of the selected internal register
	logic int_out;	// serial output of the chosen register

	always_comb begin
		int_out = bypass_cell;
		unique case (dr_sel)
			reg_bypass: int_out = bypass_cell;
			reg_select: int_out = sel_shift[0];
			reg_boundary: int_out = boundary_cells[0];
			reg_tag_bus: int_out = boundary_cells[0];
			reg_counter: int_out = event_counter_shift[0];
		endcase
	end

	// test data out changes on the falling test clock edge
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tdo_o <= 1'b0;
			tdo_oe_o <= 1'b0;
		end else begin
			if (tck_fall)
				tdo_o <= st_shift_ir ? ir_scan_out_i : int_out;
			if (tck_fall)
				tdo_oe_o <= st_shifting;
		end
	end
endmodule

// file: scan_linker_defs.svh
// constants for the scan-path linker data registers: widths, field positions, reset values
`ifndef SCAN_LINKER_DEFS_SVH
`define SCAN_LINKER_DEFS_SVH

// number of secondary chains and width of the chain-select register
`define NUM_CHAINS 4
`define CHAIN_SEL_WIDTH 8
`define CHAIN_SEL_RESET 8'h00

// boundary register and its tag-bus subset
`define BOUNDARY_WIDTH 10
`define TAG_BUS_WIDTH 4
`define BND_MASTER_COND_IN 9
`define BND_MASTER_COND_OUT 8
`define BND_COND_IN 7
`define BND_COND_OUT_TS_EN_N 6
`define BND_COND_OUT_OD_EN_N 5
`define BND_COND_OUT 4

// bypass cell capture value
`define BYPASS_CAPTURE 1'b0

// event counter and its shift register
`define COUNT_WIDTH 8
`define COUNT_SHIFT_RESET 8'h00
`define COUNT_ALL_ZERO 8'h00
`define COUNT_ALL_ONE 8'hff

// control-word bit positions used by the counter
`define CTL_WIDTH 10
`define CTL_DIR_DOWN 9
`define CTL_STOP_ZERO 8
`define CTL_ROUTE_HI 6
`define CTL_ROUTE_LO 5
`define CTL_EDGE_FALL 1
`define CTL_ROUTE_COUNT_END 2'b10

// depth of the counter log buffer
`define LOG_DEPTH 8

`endif

// file: scan_linker_pkg.sv
// types shared by the scan-path linker data register logic
package scan_linker_pkg;

	// test access port controller states, as reported by the controller
	typedef enum logic [3:0] {
		tap_reset = 4'b0000,
		tap_idle = 4'b0001,
		tap_sel_dr = 4'b0010,
		tap_capture_dr = 4'b0011,
		tap_shift_dr = 4'b0100,
		tap_exit1_dr = 4'b0101,
		tap_pause_dr = 4'b0110,
		tap_exit2_dr = 4'b0111,
		tap_update_dr = 4'b1000,
		tap_sel_ir = 4'b1001,
		tap_capture_ir = 4'b1010,
		tap_shift_ir = 4'b1011,
		tap_exit1_ir = 4'b1100,
		tap_pause_ir = 4'b1101,
		tap_exit2_ir = 4'b1110,
		tap_update_ir = 4'b1111
	} tap_state_e;

	// internal data register chosen by the current instruction
	typedef enum logic [2:0] {
		reg_bypass = 3'b000,
		reg_select = 3'b001,
		reg_boundary = 3'b010,
		reg_tag_bus = 3'b011,
		reg_counter = 3'b100
	} data_reg_e;

endpackage

// file: sync_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];	// storage flops, indexed by pointer
	logic [AW-1:0] wr_ptr;	// next slot to write
	logic [AW-1:0] rd_ptr;	// oldest slot
	logic [AW:0] fill;	// number of words held
	wire push = in_valid_i & in_ready_o;
	wire pop = out_valid_o & out_ready_i;
	wire [AW-1:0] wr_ptr_inc = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
	wire [AW-1:0] rd_ptr_inc = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

	// full and empty come straight from the fill count
	assign in_ready_o = (fill != (AW + 1)'(DEPTH));
	assign out_valid_o = (fill != '0);
	assign out_data_o = mem[rd_ptr];

	// pointer and fill bookkeeping
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			fill <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr_inc;
			if (pop)
				rd_ptr <= rd_ptr_inc;
			if (push && !pop)
				fill <= fill + 1'b1;
			else if (pop && !push)
				fill <= fill - 1'b1;
		end
	end

	// data storage, no reset needed
	always_ff @(posedge mclk_i) begin
		if (push)
			mem[wr_ptr] <= in_data_i;
	end
endmodule

// file: scan_linker_regs_properties.sv
// concurrent checks on the ports of the scan-path linker data registers
`timescale 1ns/1ps
`include "scan_linker_defs.svh"
module scan_linker_regs_properties
	import scan_linker_pkg::*;
#(
	parameter int NCH = 4
) (
	input wire logic mclk_i,
	input wire logic arst_n_i,
	input wire logic tck_i,
	input wire logic tms_i,
	input wire logic tdo_o,
	input wire logic tdo_oe_o,
	input wire tap_state_e tap_state_i,
	input wire logic [`CTL_WIDTH-1:0] control_word_i,
	input wire logic [NCH-1:0] chain_mode_select_out_o,
	input wire logic [NCH-1:0] chain_data_out_o,
	input wire logic [NCH-1:0] chain_data_out_oe_o,
	input wire logic count_end_to_cond_out_o,
	input wire logic count_log_valid_o,
	input wire logic count_log_ready_i,
	input wire logic [`COUNT_WIDTH-1:0] count_log_data_o
);
	logic tck_m; // first synchroniser stage of the test clock
	logic tck_s; // test clock as the logic sees it
	// two-flop view of the test clock
	always_ff @(posedge mclk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tck_m <= 1'b0;
			tck_s <= 1'b0;
		end else begin
			tck_m <= tck_i;
			tck_s <= tck_m;
		end
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!arst_n_i);
	property p_oe_shift;
		|chain_data_out_oe_o |-> tap_state_i inside {tap_shift_dr, tap_shift_ir};
	endproperty
	a_oe_shift: assert property (p_oe_shift) else $error("chain out outside shift");
	property p_follow;
		|chain_data_out_oe_o |-> (chain_data_out_oe_o &
			(chain_mode_select_out_o ^ {NCH{$past(tms_i, 3)}})) == '0;
	endproperty
	a_follow: assert property (p_follow) else $error("active chain not on tms");
	property p_tap_rst;
		(tap_state_i == tap_reset) [*3] |=> chain_mode_select_out_o == '1;
	endproperty
	a_tap_rst: assert property (p_tap_rst) else $error("select not cleared");
	property p_tdo_oe;
		$rose(tdo_oe_o) |-> $past(tap_state_i) inside {tap_shift_dr, tap_shift_ir};
	endproperty
	a_tdo_oe: assert property (p_tdo_oe) else $error("tdo enabled outside shift");
	property p_tdo_low;
		$changed(tdo_o) |-> !tck_s;
	endproperty
	a_tdo_low: assert property (p_tdo_low) else $error("tdo moved with tck high");
	property p_dly;
		$changed(chain_data_out_o) |-> tck_s;
	endproperty
	a_dly: assert property (p_dly) else $error("delay flop moved off rise");
	property p_route;
		1'b1 |=> count_end_to_cond_out_o == ($past(control_word_i[6:5]) == 2'b10);
	endproperty
	a_route: assert property (p_route) else $error("count end routing wrong");
	property p_log_hold;
		count_log_valid_o && !count_log_ready_i |=> count_log_valid_o && $stable(count_log_data_o);
	endproperty
	a_log_hold: assert property (p_log_hold) else $error("log word lost");
endmodule
bind scan_linker_regs scan_linker_regs_properties #(.NCH(NCH)) scan_linker_regs_properties_i (
	.mclk_i(mclk_i), .arst_n_i(arst_n_i), .tck_i(tck_i), .tms_i(tms_i), .tdo_o(tdo_o),
	.tdo_oe_o(tdo_oe_o), .tap_state_i(tap_state_i), .control_word_i(control_word_i),
	.chain_mode_select_out_o(chain_mode_select_out_o), .chain_data_out_o(chain_data_out_o),
	.chain_data_out_oe_o(chain_data_out_oe_o), .count_log_valid_o(count_log_valid_o),
	.count_end_to_cond_out_o(count_end_to_cond_out_o), .count_log_ready_i(count_log_ready_i),
	.count_log_data_o(count_log_data_o));

// file: chain_partner.sv
// four one-cell secondary scan chains hanging off the linker
`timescale 1ns/1ps
module chain_partner (
	input wire logic tck_i,
	input wire logic [3:0] data_i,
	input wire logic [3:0] data_oe_i,
	output logic [3:0] data_o
);
	logic [3:0] cap = 4'h0; // bit taken at the rise
	logic [3:0] live = 4'h0; // line was driven at the rise
	initial data_o = 4'h5;
	// sample on the rise
	always @(posedge tck_i) begin
		cap <= data_i;
		live <= data_oe_i;
	end
	// present on the fall; a floating line gives no trusted value
	always @(negedge tck_i) data_o <= (cap & live) | (~data_o & ~live);
endmodule

// file: scan_linker_regs_tb.sv
// self-checking testbench for the scan-path linker data registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) fail(n, e, g); end
module scan_linker_regs_tb;
	import scan_linker_pkg::*;
	logic mclk_i = 1'b0, arst_n_i = 1'b0, tck = 1'b0, tms = 1'b0, tdi = 1'b0;
	logic cin = 1'b0, rdy = 1'b0, tdo, tdo_oe, ce_n, ce_rt, lv;
	logic bd = 1'b0, master_condition_out, co, co_oe; // boundary force and the pins it drives
	logic [3:0] ms, cdo, cdo_oe, cdi, tgo, tgo_oe;
	logic [7:0] ld, p, exp8;
	logic [9:0] ctl = 10'h000;
	logic [15:0] misc = 16'h0000, v;
	tap_state_e st = tap_reset;
	data_reg_e ir = reg_bypass;
	int n_errors = 0, samples_checked = 0, cyc = 0, seed = 36548;
	logic [1:0] q_tdo[$]; // care bit and expected tdo per shift fall
	logic [7:0] q_cnt[$]; // expected log words
	event tdo_due;
	initial forever #25 mclk_i = ~mclk_i;
	scan_linker_regs scan_linker_regs_i (
		.mclk_i(mclk_i), .arst_n_i(arst_n_i), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
		.tdo_o(tdo), .tdo_oe_o(tdo_oe), .tap_state_i(st), .instr_reg_i(ir),
		.ir_scan_in_o(), .ir_scan_out_i(misc[0]), .control_word_i(ctl),
		.chain_mode_select_out_o(ms), .chain_data_out_o(cdo), .chain_data_out_oe_o(cdo_oe),
		.chain_data_in_i(cdi), .condition_input_i(cin), .master_condition_in_i(misc[1]),
		.func_master_cond_out_i(misc[2]), .func_cond_out_i(misc[3]),
		.func_cond_out_oe_i(misc[4]), .func_cond_out_ts_en_n_i(misc[5]),
		.func_cond_out_od_en_n_i(misc[6]), .boundary_drive_i(bd),
		.master_condition_out_o(master_condition_out), .condition_output_o(co), .condition_output_oe_o(co_oe),
		.tag_bus_pins_i(misc[10:7]), .tag_bus_pins_o(tgo), .tag_bus_pins_oe_o(tgo_oe),
		.count_end_n_o(ce_n), .count_end_to_cond_out_o(ce_rt),
		.count_log_valid_o(lv), .count_log_ready_i(rdy), .count_log_data_o(ld));
	chain_partner chain_partner_i (.tck_i(tck), .data_i(cdo), .data_oe_i(cdo_oe), .data_o(cdi));
	// random functional and pin inputs
	always @(negedge mclk_i) misc <= 16'($random(seed));
	task automatic fail(input string n, input logic [15:0] e, input logic [15:0] g);
		n_errors++;
		$display("BAD %s expected %h seen %h", n, e, g);
	endtask
	task automatic results;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// one test clock period: rise acts on the current state, fall on nxt
	task automatic step(input tap_state_e nxt, input logic b, input logic [1:0] ex);
		tdi = b;
		w(4);
		tck = 1'b1;
		w(4);
		st = nxt;
		w(1);
		tck = 1'b0;
		w(6);
		if (nxt == tap_shift_dr) begin
			q_tdo.push_back(ex);
			-> tdo_due;
		end
	endtask
	task automatic dr_scan(input logic [15:0] v, input int n, input logic [15:0] e,
		input logic [15:0] c);
		step(tap_sel_dr, 1'b0, 2'b00);
		step(tap_capture_dr, 1'b0, 2'b00);
		step(tap_shift_dr, 1'b0, {c[0], e[0]});
		for (int i = 0; i < n; i++) begin
			step(i == n - 1 ? tap_exit1_dr : tap_shift_dr, v[i], {c[i + 1], e[i + 1]});
		end
		step(tap_update_dr, 1'b0, 2'b00);
	endtask
	task automatic set_ir(input data_reg_e r);
		ir = r;
		step(tap_update_ir, 1'b0, 2'b00);
		step(tap_idle, 1'b0, 2'b00);
	endtask
	task automatic edges(input int n);
		repeat (n) begin
			cin = 1'b1;
			w(4);
			cin = 1'b0;
			w(4);
		end
	endtask
	// tdo watcher: one note per shift fall
	always @(tdo_due) begin
		if (q_tdo[0][1]) `CHK("tdo", {1'b1, q_tdo[0][0]}, {tdo_oe, tdo})
		void'(q_tdo.pop_front());
	end
	// log watcher: one note per word popped
	always @(posedge mclk_i) begin
		if (lv === 1'b1 && rdy) begin
			if (q_cnt.size() == 0) fail("log extra", 16'h0000, ld);
			else begin
				exp8 = q_cnt.pop_front();
				`CHK("log", exp8, ld)
			end
		end
	end
	// hang guard
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			results();
		end
	end
	initial begin
		w(6);
		arst_n_i = 1'b1;
		w(4);
		`CHK("mode", 4'hf, ms)
		st = tap_idle;
		w(2);
		// bypass after power-up captures zero
		v = 16'($random(seed));
		dr_scan(v, 6, {v[14:0], 1'b0}, 16'h003f);
		step(tap_idle, 1'b0, 2'b00);
		// boundary: shift a pattern through, then let the update latch force the pins
		set_ir(reg_boundary);
		v = 16'($random(seed));
		dr_scan(v, 16, v << 10, 16'hfc00);
		bd = 1'b1;
		w(4);
		p = {1'b0, v[14], v[10], ~v[12] | (~v[11] & ~v[10]), v[9:6]};
		`CHK("bnd pins", p, {1'b0, master_condition_out, co, co_oe, tgo})
		`CHK("tag oe", 4'hf, tgo_oe)
		// tag-bus cells alone: the other forced pins keep their values
		set_ir(reg_tag_bus);
		dr_scan(v >> 8, 8, (v >> 8) << 4, 16'h00f0);
		`CHK("tag only", {v[14], v[10], v[15:12]}, {master_condition_out, co, tgo})
		step(tap_idle, 1'b0, 2'b00);
		// counter: preload, fill the log while stalled, then drain
		set_ir(reg_counter);
		ctl = 10'h040;
		p = 8'($random(seed)) & 8'h7f;
		dr_scan({8'h00, p}, 8, 16'h0000, 16'h0000);
		step(tap_idle, 1'b0, 2'b00);
		for (int k = 1; k < 10; k++) q_cnt.push_back(p + 8'(k));
		edges(10);
		`CHK("log full", 1'b1, lv)
		rdy = 1'b1;
		w(20);
		`CHK("log empty", 1'b0, lv)
		dr_scan(16'h00fe, 8, {8'h00, p + 8'h09}, 16'h00ff);
		step(tap_idle, 1'b0, 2'b00);
		q_cnt.push_back(8'hff);
		edges(1);
		w(6);
		`CHK("up end", 1'b0, ce_n)
		`CHK("route", 1'b1, ce_rt)
		// count down on falling edges, stop at zero
		ctl = 10'h302;
		dr_scan(16'h0001, 8, 16'h00ff, 16'h00ff);
		step(tap_idle, 1'b0, 2'b00);
		q_cnt.push_back(8'h00);
		edges(3);
		w(6);
		`CHK("down end", 1'b0, ce_n)
		// first chain select holds its mode line low until idle
		tms = 1'b1;
		set_ir(reg_select);
		dr_scan(16'h0002, 8, 16'h0000, 16'h00ff);
		`CHK("hold", 4'he, ms)
		step(tap_idle, 1'b0, 2'b00);
		`CHK("follow", 4'hf, ms)
		// two extra shifts: the delay flop and the one-cell chain sit ahead of the register
		dr_scan(16'h004a, 10, 16'h0002, 16'h00ff);
		`CHK("handover", 4'h7, ms)
		step(tap_idle, 1'b0, 2'b00);
		`CHK("idle float", 4'h0, cdo_oe)
		// chains one and two ahead of the bypass cell
		set_ir(reg_bypass);
		v = 16'($random(seed));
		dr_scan(v, 12, v << 5, 16'h0fe0);
		step(tap_idle, 1'b0, 2'b00);
		results();
	end
endmodule
